// ### rtl/iprx_pkg.sv
package iprx_pkg;

  localparam int CNT_W = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 125_000_000;
  // narrowest legal light pulse from the detector
  localparam int MIN_PULSE_NS = 1670;
  localparam int MIN_PULSE_CYC_I = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] MIN_PULSE_CYC = CNT_W'(MIN_PULSE_CYC_I);
  // fastest selectable bit rate and the receiver oversampling ratio
  localparam int MAX_BIT_RATE = 115_200;
  localparam int OVERSAMPLE = 8;
  localparam int RX_DIV_MIN_I = CLK_HZ / (OVERSAMPLE * MAX_BIT_RATE);
  localparam logic [CNT_W-1:0] RX_DIV_MIN = CNT_W'(RX_DIV_MIN_I);
  localparam logic [2:0] START_MID_PHASE = 3'h3;
  localparam logic [2:0] BIT_LAST_PHASE = 3'h7;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // smallest legal compare value, so the compare-true phase spans at least two counter ticks
  localparam logic [CNT_W-1:0] MIN_COMPARE = 16'h0001;

  typedef enum logic [1:0] {
    IPRX_IDLE = 2'b00,
    IPRX_START = 2'b01,
    IPRX_DATA = 2'b10,
    IPRX_STOP = 2'b11
  } iprx_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] os_div;
    logic [CNT_W-1:0] os_period;
    logic [CNT_W-1:0] os_compare;
    logic [CNT_W-1:0] rx_div;
    logic irq_en;
  } iprx_cfg_t;

  typedef struct packed {
    logic full;
    logic frame_err;
    logic overrun;
  } iprx_status_t;

  // free-running divider, wraps to zero after div+1 clocks
  function automatic logic [CNT_W-1:0] div_next(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] div);
    div_next = (cnt >= div) ? CNT_ZERO : CNT_W'(cnt + CNT_ONE);
  endfunction

endpackage

// ### rtl/iprx_pulse_stretch.sv
`timescale 1ns/10ps
module iprx_pulse_stretch (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic det,
  input wire logic [iprx_pkg::CNT_W-1:0] os_div,
  input wire logic [iprx_pkg::CNT_W-1:0] os_period,
  input wire logic [iprx_pkg::CNT_W-1:0] os_compare,
  output logic stretch_out
);

  typedef struct packed {
    logic [iprx_pkg::CNT_W-1:0] div;
    logic [iprx_pkg::CNT_W-1:0] count;
    logic out;
  } iprx_os_state_t;

  iprx_os_state_t s_q, s_d;
  logic enable;
  logic tick;

  always_comb begin
    s_d = s_q;
    // inverted and of detector and own output feeds the enable
    enable = ~(det & s_q.out);
    tick = (s_q.div == iprx_pkg::CNT_ZERO);
    s_d.div = iprx_pkg::div_next(s_q.div, os_div);
    if (tick) begin
      if (!enable) begin
        s_d.count = iprx_pkg::CNT_ZERO;
      end else if (s_q.count == iprx_pkg::CNT_ZERO) begin
        s_d.count = os_period;
      end else begin
        s_d.count = iprx_pkg::CNT_W'(s_q.count - iprx_pkg::CNT_ONE);
      end
    end
    // low until the compare-true tail, no extra output inversion
    s_d.out = (s_d.count <= os_compare);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{div: 16'h0000, count: 16'h0000, out: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign stretch_out = s_q.out;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  pulse_trigger_a: assert property (!det |-> enable)
    else $error("detector pulse did not force the counter enable");
  stretch_low_a: assert property (s_q.count > os_compare |-> !stretch_out)
    else $error("one-shot output high before the compare-true tail");
  self_hold_a: assert property (tick && !stretch_out && s_q.count > os_compare
      |=> s_q.count == $past(s_q.count) - 16'h0001)
    else $error("one-shot counter stopped while stretching");
  retrig_c: cover property (tick && !det && !stretch_out);

endmodule // iprx_pulse_stretch

// ### rtl/iprx_receiver.sv
`timescale 1ns/10ps
// Functional notes
// - frame is one start, eight data, one stop bit, no parity.
// - bit rate selectable by divider, up to 115.2 kbps.
// - serial input idles high; start low, stop high, sampled mid-bit.
// - counter forms retriggerable one-shot widening each pulse to nearly a full bit.
// - detector output and one-shot output are anded into the receiver.
// - anded level is inverted into the counter enable, no output inversion.
// - pulse forces enable; counter then holds itself enabled for a bit.
// - compare-true time shorter than the narrowest pulse.
// - one-shot period slightly shorter than one bit.
// - compare-true phase spans at least two counter clocks.
// - receiver clocked at eight times the bit rate.
// - start bit launches divide-by-eight bit clock centred in each bit.
// - eight following bit clocks sample and shift data in.
// - stop bit sample moves assembled byte into the buffer.
// - buffer load sets full flag and interrupt when enabled.
// - missing stop bit sets the framing error flag.
// - buffer still unread at stop bit sets overrun flag.
// - receiver and companion transmitter are not run together.
module iprx_receiver (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ir_det_n,
  input wire logic tx_active,
  input wire iprx_pkg::iprx_cfg_t cfg,
  input wire logic buf_read,
  output logic [7:0] rx_data,
  output iprx_pkg::iprx_status_t status,
  output logic rx_irq,
  output logic stretch_level,
  output logic cfg_err
);

  typedef struct packed {
    iprx_pkg::iprx_state_t st;
    logic [iprx_pkg::CNT_W-1:0] div;
    logic [2:0] phase;
    logic [2:0] bits;
    logic [7:0] shift;
    logic [7:0] buffer;
    iprx_pkg::iprx_status_t stat;
    logic irq;
    logic det;
    logic serial;
    logic cfg_bad;
  } iprx_rx_state_t;

  iprx_rx_state_t s_q, s_d;
  logic stretch;
  logic tick;
  logic stop_done;
  logic [iprx_pkg::CNT_W:0] tail_cyc;
  logic [iprx_pkg::CNT_W:0] os_tick_cyc;

  iprx_pulse_stretch u_stretch (
    .clock(clock),
    .reset_n(reset_n),
    .det(s_q.det),
    .os_div(cfg.os_div),
    .os_period(cfg.os_period),
    .os_compare(cfg.os_compare),
    .stretch_out(stretch)
  );

  always_comb begin
    s_d = s_q;
    tick = (s_q.div == iprx_pkg::CNT_ZERO);
    stop_done = 1'b0;
    s_d.det = ir_det_n;
    // quiet while the companion transmitter is active
    s_d.serial = (s_q.det & stretch) | tx_active;
    // one receiver tick per eighth of a bit
    s_d.div = iprx_pkg::div_next(s_q.div, cfg.rx_div);
    if (tick) begin
      unique case (s_q.st)
        iprx_pkg::IPRX_IDLE: begin
          if (!s_q.serial) begin
            s_d.st = iprx_pkg::IPRX_START;
            s_d.phase = 3'h1;
          end
        end
        iprx_pkg::IPRX_START: begin
          if (s_q.phase == iprx_pkg::START_MID_PHASE) begin
            // realign bit clock to the centre of the start bit
            s_d.phase = 3'h0;
            s_d.bits = 3'h0;
            s_d.st = s_q.serial ? iprx_pkg::IPRX_IDLE : iprx_pkg::IPRX_DATA;
          end else begin
            s_d.phase = 3'(s_q.phase + 3'h1);
          end
        end
        iprx_pkg::IPRX_DATA: begin
          s_d.phase = 3'(s_q.phase + 3'h1);
          if (s_q.phase == iprx_pkg::BIT_LAST_PHASE) begin
            s_d.shift = {s_q.serial, s_q.shift[7:1]};
            s_d.bits = 3'(s_q.bits + 3'h1);
            if (s_q.bits == iprx_pkg::LAST_DATA_BIT) begin
              s_d.st = iprx_pkg::IPRX_STOP;
            end
          end
        end
        iprx_pkg::IPRX_STOP: begin
          s_d.phase = 3'(s_q.phase + 3'h1);
          if (s_q.phase == iprx_pkg::BIT_LAST_PHASE) begin
            stop_done = 1'b1;
            s_d.st = iprx_pkg::IPRX_IDLE;
          end
        end
      endcase
    end
    // read clears flags; a completing frame wins over the read
    if (buf_read) begin
      s_d.stat = '{full: 1'b0, frame_err: 1'b0, overrun: 1'b0};
    end
    if (stop_done) begin
      s_d.buffer = s_q.shift;
      s_d.stat.full = 1'b1;
      s_d.stat.frame_err = !s_q.serial;
      s_d.stat.overrun = s_q.stat.full & !buf_read;
    end
    s_d.irq = s_d.stat.full & cfg.irq_en;
    // compare-true tail in clocks: (compare+1) ticks of (os_div+1) clocks
    os_tick_cyc = {1'b0, cfg.os_div} + 17'h0_0001;
    tail_cyc = 17'((({1'b0, cfg.os_compare} + 17'h0_0001) * os_tick_cyc));
    s_d.cfg_bad = (cfg.os_compare < iprx_pkg::MIN_COMPARE)
      || (tail_cyc >= {1'b0, iprx_pkg::MIN_PULSE_CYC})
      || (cfg.os_period <= cfg.os_compare)
      || (cfg.rx_div < iprx_pkg::RX_DIV_MIN);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{st: iprx_pkg::IPRX_IDLE, div: 16'h0000, phase: 3'h0, bits: 3'h0,
               shift: 8'h00, buffer: 8'h00, stat: 3'h0, irq: 1'b0, det: 1'b1,
               serial: 1'b1, cfg_bad: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_data = s_q.buffer;
  assign status = s_q.stat;
  assign rx_irq = s_q.irq;
  assign stretch_level = s_q.serial;
  assign cfg_err = s_q.cfg_bad;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  serial_and_a: assert property (!tx_active && !s_q.det |=> !stretch_level)
    else $error("detector low did not pull the receiver input low");
  tx_quiet_a: assert property (tx_active |=> stretch_level)
    else $error("receiver input not idle while transmitter active");
  start_detect_a: assert property (s_q.st == iprx_pkg::IPRX_IDLE && tick && !s_q.serial
      |=> s_q.st == iprx_pkg::IPRX_START && s_q.phase == 3'h1)
    else $error("start bit not picked up");
  shift_in_a: assert property (s_q.st == iprx_pkg::IPRX_DATA && tick && s_q.phase == 3'h7
      |=> s_q.shift[7] == $past(s_q.serial))
    else $error("data bit not shifted in at bit centre");
  buffer_load_a: assert property (stop_done |=> rx_data == $past(s_q.shift) && status.full)
    else $error("stop bit did not load buffer and set full");
  irq_follow_a: assert property (stop_done && cfg.irq_en |=> rx_irq)
    else $error("interrupt not raised on buffer load");
  frame_flag_a: assert property (stop_done && !s_q.serial |=> status.frame_err)
    else $error("missing stop bit not flagged");
  overrun_flag_a: assert property (stop_done && status.full && !buf_read |=> status.overrun)
    else $error("unread buffer at stop bit not flagged");
  read_clear_a: assert property (buf_read && !stop_done |=> !status.full)
    else $error("buffer read did not clear full");
  frame_len_a: assert property (s_q.st == iprx_pkg::IPRX_START && tick && s_q.phase == 3'h3 && !s_q.serial
      |=> s_q.st == iprx_pkg::IPRX_DATA && s_q.bits == 3'h0)
    else $error("data phase not entered after valid start");

  // frame sequencing
  idle_stay_a: assert property (s_q.st == iprx_pkg::IPRX_IDLE && (!tick || s_q.serial)
      |=> s_q.st == iprx_pkg::IPRX_IDLE)
    else $error("receiver left idle without a start bit");

  start_step_a: assert property (s_q.st == iprx_pkg::IPRX_START && tick && s_q.phase != 3'h3
      |=> s_q.st == iprx_pkg::IPRX_START && s_q.phase == $past(s_q.phase) + 3'h1)
    else $error("start bit phase did not advance");

  false_start_a: assert property (s_q.st == iprx_pkg::IPRX_START && tick && s_q.phase == 3'h3 && s_q.serial
      |=> s_q.st == iprx_pkg::IPRX_IDLE)
    else $error("high level at start centre not rejected");

  data_step_a: assert property (s_q.st == iprx_pkg::IPRX_DATA && tick
      |=> s_q.phase == $past(s_q.phase) + 3'h1)
    else $error("bit clock phase did not advance in data");

  data_stay_a: assert property (s_q.st == iprx_pkg::IPRX_DATA && tick && !(s_q.phase == 3'h7 && s_q.bits == 3'h7)
      |=> s_q.st == iprx_pkg::IPRX_DATA)
    else $error("data phase left before eight bits");

  bits_count_a: assert property (s_q.st == iprx_pkg::IPRX_DATA && tick && s_q.phase == 3'h7
      |=> s_q.bits == $past(s_q.bits) + 3'h1)
    else $error("bit counter did not advance on shift");

  bits_to_stop_a: assert property (s_q.st == iprx_pkg::IPRX_DATA && tick && s_q.phase == 3'h7 && s_q.bits == 3'h7
      |=> s_q.st == iprx_pkg::IPRX_STOP)
    else $error("stop bit not awaited after eighth data bit");

  stop_step_a: assert property (s_q.st == iprx_pkg::IPRX_STOP && tick && s_q.phase != 3'h7
      |=> s_q.st == iprx_pkg::IPRX_STOP)
    else $error("stop bit left before its centre");

  stop_idle_a: assert property (stop_done
      |=> s_q.st == iprx_pkg::IPRX_IDLE)
    else $error("receiver not idle after stop bit");

  // bit clock divider
  tick_step_a: assert property (tick && cfg.rx_div != 16'h0000
      |=> s_q.div == 16'h0001)
    else $error("receiver divider did not restart after tick");

  no_tick_hold_a: assert property (!tick
      |=> $stable(s_q.st) && $stable(s_q.phase) && $stable(s_q.bits) && $stable(s_q.shift))
    else $error("receiver state moved between ticks");

  // buffer, flags, interrupt and receiver input level
  buffer_hold_a: assert property (!stop_done
      |=> $stable(rx_data))
    else $error("buffer changed without a completed frame");

  full_rise_a: assert property ($rose(status.full)
      |-> $past(stop_done))
    else $error("full flag set without a completed frame");

  irq_mask_a: assert property (!cfg.irq_en
      |=> !rx_irq)
    else $error("interrupt raised while disabled");

  irq_level_a: assert property (cfg.irq_en && status.full && !buf_read
      |=> rx_irq)
    else $error("interrupt not held while buffer full");

  read_err_clear_a: assert property (buf_read && !stop_done
      |=> !status.frame_err && !status.overrun)
    else $error("buffer read did not clear error flags");

  flags_hold_a: assert property (!buf_read && !stop_done
      |=> $stable(status))
    else $error("status changed without read or frame");

  complete_wins_a: assert property (stop_done && buf_read
      |=> status.full && !status.overrun)
    else $error("read in completion cycle mishandled");

  frame_ok_a: assert property (stop_done && s_q.serial
      |=> !status.frame_err)
    else $error("framing error on a good stop bit");

  no_overrun_a: assert property (stop_done && !status.full
      |=> !status.overrun)
    else $error("overrun flagged with empty buffer");

  serial_high_a: assert property (!tx_active && s_q.det && stretch
      |=> stretch_level)
    else $error("receiver input low with both inputs high");

  // configuration limits
  cfg_min_a: assert property (cfg.os_compare < iprx_pkg::MIN_COMPARE
      |=> cfg_err)
    else $error("too short compare phase not flagged");

  cfg_period_a: assert property (cfg.os_period <= cfg.os_compare
      |=> cfg_err)
    else $error("one-shot period not above compare");

  cfg_rate_a: assert property (cfg.rx_div < iprx_pkg::RX_DIV_MIN
      |=> cfg_err)
    else $error("bit rate above maximum not flagged");

  cfg_tail_a: assert property (tail_cyc >= {1'b0, iprx_pkg::MIN_PULSE_CYC}
      |=> cfg_err)
    else $error("compare phase longer than pulse not flagged");

  byte_c: cover property (stop_done && s_q.serial);
  frame_err_c: cover property (stop_done && !s_q.serial);
  overrun_c: cover property (stop_done && status.full);
  false_start_c: cover property (s_q.st == iprx_pkg::IPRX_START && tick && s_q.phase == 3'h3 && s_q.serial);

endmodule // iprx_receiver

// ### verification/iprx_det_model.sv
`timescale 1ns/10ps
module iprx_det_model #(
  parameter int BIT_CYC = 1120,
  parameter int PULSE_CYC = 209
) (
  input wire logic clock,
  output logic ir_det_n
);
  // dark detector output idles high
  initial ir_det_n = 1'b1;

  // one bit slot, light only for a zero; call at a falling edge
  task automatic bit_slot(input logic b);
    if (!b) begin
      ir_det_n = 1'b0;
      repeat (PULSE_CYC) @(negedge clock);
      ir_det_n = 1'b1;
      repeat (BIT_CYC - PULSE_CYC) @(negedge clock);
    end else begin
      repeat (BIT_CYC) @(negedge clock);
    end
  endtask

  task automatic send(input logic [7:0] data, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      bit_slot(frame[i]);
    end
  endtask
endmodule // iprx_det_model

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clock;
  logic reset_n;
  logic ir_det_n;
  logic tx_active;
  iprx_pkg::iprx_cfg_t cfg;
  logic buf_read;
  logic [7:0] rx_data;
  iprx_pkg::iprx_status_t status;
  logic rx_irq;
  logic stretch_level;
  logic cfg_err;
  int fails = 0;
  int tests_run = 0;

  iprx_receiver uut (.clock(clock), .reset_n(reset_n), .ir_det_n(ir_det_n), .tx_active(tx_active), .cfg(cfg),
    .buf_read(buf_read), .rx_data(rx_data), .status(status), .rx_irq(rx_irq), .stretch_level(stretch_level),
    .cfg_err(cfg_err));
  // bit of 1120 clocks: 3/16 bit is 210, so a 209 clock pulse is legal
  iprx_det_model #(.BIT_CYC(1120), .PULSE_CYC(209)) det (.clock(clock), .ir_det_n(ir_det_n));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic read_buf();
    buf_read = 1'b1;
    @(negedge clock);
    buf_read = 1'b0;
    check(8'(status), 8'h00);
    @(negedge clock);
    check(8'(rx_irq), 8'h00);
  endtask

  task automatic t_reset();
    check(rx_data, 8'h00);
    check(8'(status), 8'h00);
    check(8'(rx_irq), 8'h00);
    check(8'(stretch_level), 8'h01);
    check(8'(cfg_err), 8'h00);
  endtask

  task automatic t_stretch();
    fork
      det.bit_slot(1'b0);
    join_none
    repeat (4) @(negedge clock);
    check(8'(stretch_level), 8'h00);
    repeat (996) @(negedge clock);
    check(8'(stretch_level), 8'h00);
    repeat (150) @(negedge clock);
    check(8'(stretch_level), 8'h01);
    // transmitter busy: light must not reach the receiver
    tx_active = 1'b1;
    fork
      det.bit_slot(1'b0);
    join_none
    repeat (100) @(negedge clock);
    check(8'(stretch_level), 8'h01);
    repeat (1200) @(negedge clock);
    tx_active = 1'b0;
    repeat (1200) @(negedge clock);
    check(8'(status), 8'h00);
    // the lone pulse framed an all-ones byte; let it land
    repeat (8000) @(negedge clock);
    check(rx_data, 8'hff);
    check(8'(status), 8'h04);
    read_buf();
  endtask

  task automatic t_cfg();
    cfg.os_compare = 16'h0000;
    repeat (3) @(negedge clock);
    check(8'(cfg_err), 8'h01);
    cfg.os_compare = 16'h001a;
    repeat (3) @(negedge clock);
    check(8'(cfg_err), 8'h01);
    cfg.os_compare = 16'h0002;
    cfg.rx_div = 16'h0086;
    repeat (3) @(negedge clock);
    check(8'(cfg_err), 8'h01);
    cfg.rx_div = 16'h008b;
    repeat (3) @(negedge clock);
    check(8'(cfg_err), 8'h00);
  endtask

  task automatic t_frames();
    det.send(8'ha5, 1'b1);
    check(rx_data, 8'ha5);
    check(8'(status), 8'h04);
    check(8'(rx_irq), 8'h01);
    read_buf();
    cfg.irq_en = 1'b0;
    det.send(8'h00, 1'b1);
    det.send(8'hff, 1'b1);
    check(rx_data, 8'hff);
    check(8'(status), 8'h05);
    check(8'(rx_irq), 8'h00);
    read_buf();
    cfg.irq_en = 1'b1;
    det.send(8'h3c, 1'b0);
    check(rx_data, 8'h3c);
    check(8'(status), 8'h06);
    // low stop bit looks like a new start; let that frame finish
    repeat (12000) @(negedge clock);
    check(rx_data, 8'hff);
    check(8'(status), 8'h05);
    read_buf();
  endtask

  initial begin
    #(90_000 * 8);
    fails++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    tx_active = 1'b0;
    buf_read = 1'b0;
    cfg = '{os_div: 16'h0007, os_period: 16'h0088, os_compare: 16'h0002, rx_div: 16'h008b, irq_en: 1'b1};
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    t_reset();
    t_cfg();
    t_stretch();
    t_frames();
    final_report();
  end
endmodule // testbench
